// ==== clkgen_defines.vh ====
// constants for the system clock generation unit
// assumes a single 100 MHz core clock and a plain strobe register port
`ifndef CLKGEN_DEFINES_VH
`define CLKGEN_DEFINES_VH
// register offsets (word index on the plain port)
`define CCR_ADDR 4'h0
`define VRC_ADDR 4'h1
`define CFR_ADDR 4'h2
`define PLC_ADDR 4'h3
`define RTC_ADDR 4'h4
`define PCG_ADDR 4'h5
// flag register fields
`define CFR_HALVE 15
`define CFR_STOP_I 14
`define CFR_SLOW_I 13
`define CFR_LOCK_I 11
`define CFR_SLOW 3
`define CFR_LOCK 1
`define CFR_PLLSEL 0
`define CFR_RESET 16'h8008
// control register fields
`define CCR_EN_STOP 10
`define CCR_EN_SLOW 9
`define CCR_EN_LOCK 7
`define CCR_LPW 0
// pll control fields
`define PLC_FREE 7
`define PLC_MX_HI 5
`define PLC_MX_LO 4
`define PLC_DX_HI 2
`define PLC_DX_LO 0
`define PLC_RESET 8'h07
`define DX_OFF 3'h7
// multiplier codes
`define MX_X20 2'h0
`define MX_X12 2'h1
`define MX_X28 2'h2
`define MX_X16 2'h3
// timing
`define SLOW_DIV 5'h10
`define PERIPH_RST_CYC 4'h8
`define SWITCH_SETTLE 3'h3
`define LOCK_CYC 8'h40
`endif

// ==== clock_gate_reset.v ====
// one peripheral clock gate with a held reset after each enable
// assumes gate_in comes from a register in the core clock domain
`timescale 1ns/1ps
`include "clkgen_defines.vh"
module clock_gate_reset (
    input wire core_clk_in,
    input wire rst_in,
    input wire gate_in,
    output reg clk_en_out,
    output reg periph_rst_out
);
    reg [3:0] cnt_r;
    reg gate_d_r;
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            gate_d_r <= 1'b0;
            cnt_r <= 4'h0;
            clk_en_out <= 1'b0;
            periph_rst_out <= 1'b1;
        end else begin
            gate_d_r <= gate_in;
            clk_en_out <= gate_in;
            if (gate_in && !gate_d_r) begin
                cnt_r <= `PERIPH_RST_CYC;
                periph_rst_out <= 1'b1;
            end else if (!gate_in) begin
                periph_rst_out <= 1'b1;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
                periph_rst_out <= (cnt_r != 4'h1);
            end else begin
                periph_rst_out <= 1'b0;
            end
        end
    end
endmodule // clock_gate_reset

// ==== rt_prescaler.v ====
// real-time clock prescaler dividing the oscillator tick by 2..1024
// assumes osc_tick_in is a one-cycle pulse per oscillator period
`timescale 1ns/1ps
module rt_prescaler #(
    parameter W = 10
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire osc_tick_in,
    input wire [W-1:0] div_in,
    output reg rt_tick_out
);
    reg [W-1:0] cnt_r;
    // div_in holds factor-1; zero is treated as divide by two
    wire [W-1:0] lim = (div_in == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : div_in;
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            cnt_r <= {W{1'b0}};
            rt_tick_out <= 1'b0;
        end else begin
            rt_tick_out <= 1'b0;
            if (osc_tick_in) begin
                if (cnt_r >= lim) begin
                    cnt_r <= {W{1'b0}};
                    rt_tick_out <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // rt_prescaler

// ==== clock_generation_unit.v ====
// system clock generation unit: source selection, pll model, gating
// assumes clocks are modelled as one-cycle tick enables in core_clk_in
`timescale 1ns/1ps
`include "clkgen_defines.vh"
module clock_generation_unit #(
    parameter NPER = 8,
    parameter RTW = 10
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire root_clock_in,
    input wire osc_tick_in,
    input wire regulator_ready_flag_in,
    input wire wfi_in,
    input wire stop_wake_in,
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [15:0] rdata_out,
    output reg sys_clk_out,
    output wire [NPER-1:0] periph_clk_en_out,
    output wire [NPER-1:0] periph_rst_out,
    output wire rt_tick_out,
    output wire [2:0] irq_req_out
);
    localparam S_REF = 2'h0;
    localparam S_PLL = 2'h1;
    localparam S_SLOW = 2'h2;
    localparam S_QUIET = 2'h3;

    reg [15:0] ccr_r;
    reg [15:0] cfr_r;
    reg [15:0] cfr_nxt;
    reg [7:0] plc_r;
    reg [RTW-1:0] rtc_r;
    reg [NPER-1:0] pcg_r;
    reg ref_r;
    reg root_d_r;
    reg [3:0] slow_cnt_r;
    reg slow_clk_r;
    reg [10:0] pll_acc_r;
    reg pll_clk_r;
    reg [7:0] lock_cnt_r;
    reg lock_r;
    reg [1:0] mx_d_r;
    reg [7:0] ref_idle_r;
    reg [1:0] src_r;
    reg [1:0] want_r;
    reg [2:0] settle_r;

    wire halve = cfr_r[`CFR_HALVE];
    wire slow_sel = cfr_r[`CFR_SLOW];
    wire pll_sel = cfr_r[`CFR_PLLSEL];
    wire [1:0] mx = plc_r[`PLC_MX_HI:`PLC_MX_LO];
    wire [2:0] dx = plc_r[`PLC_DX_HI:`PLC_DX_LO];
    wire pll_off = (dx == `DX_OFF);
    wire free_run = pll_off && plc_r[`PLC_FREE];
    wire root_rise = root_clock_in && !root_d_r;
    // halving passes only every second root rising edge as a reference tick
    wire ref_tick = halve ? (root_rise && ref_r) : root_rise;
    wire ref_lost = (ref_idle_r == 8'hFF);
    reg [4:0] mult;
    always @* begin
        case (mx)
            `MX_X20: mult = 5'h14;
            `MX_X12: mult = 5'h0C;
            `MX_X28: mult = 5'h1C;
            default: mult = 5'h10;
        endcase
    end
    // model runs at reference*M/(32*D): halving doubles the reference
    // period, so the step halves; ticks stay below half the core rate
    wire [4:0] pll_period = {2'h0, dx} + 5'h1;
    wire [10:0] pll_step = halve ? {6'h00, mult}
        : {5'h00, mult, 1'b0};
    wire [10:0] pll_thr = {pll_period[3:0], 7'h00};
    wire [10:0] pll_sum = pll_acc_r + pll_step;

    always @(posedge core_clk_in) begin
        if (rst_in) begin
            ref_r <= 1'b0;
            root_d_r <= 1'b0;
            ref_idle_r <= 8'h0;
        end else begin
            root_d_r <= root_clock_in;
            if (root_rise) begin
                ref_r <= ~ref_r;
            end
            if (ref_tick) begin
                ref_idle_r <= 8'h0;
            end else if (!ref_lost) begin
                ref_idle_r <= ref_idle_r + 8'h1;
            end
        end
    end

    // slow clock: one tick every 16 reference ticks
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            slow_cnt_r <= 4'h0;
            slow_clk_r <= 1'b0;
        end else begin
            slow_clk_r <= 1'b0;
            if (ref_tick) begin
                slow_cnt_r <= slow_cnt_r + 4'h1;
                slow_clk_r <=
                    ({1'b0, slow_cnt_r} == `SLOW_DIV - 5'h01);
            end
        end
    end

    // pll output ticks; free-running once reference is gone
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            pll_acc_r <= 11'h000;
            pll_clk_r <= 1'b0;
            lock_cnt_r <= 8'h0;
            lock_r <= 1'b0;
            mx_d_r <= `MX_X20;
        end else begin
            mx_d_r <= mx;
            pll_clk_r <= 1'b0;
            if (!pll_off || free_run) begin
                if (pll_sum >= pll_thr) begin
                    // shrunk threshold restarts the phase: no tick burst
                    if ({1'b0, pll_sum} >= {pll_thr, 1'b0}) begin
                        pll_acc_r <= 11'h000;
                    end else begin
                        pll_acc_r <= pll_sum - pll_thr;
                    end
                    pll_clk_r <= 1'b1;
                end else begin
                    pll_acc_r <= pll_sum;
                end
            end
            if (pll_off || ref_lost || mx != mx_d_r) begin
                lock_cnt_r <= 8'h0;
                lock_r <= 1'b0;
            end else if (lock_cnt_r == `LOCK_CYC) begin
                lock_r <= 1'b1;
            end else if (ref_tick) begin
                lock_cnt_r <= lock_cnt_r + 8'h1;
            end
        end
    end

    // wanted source
    always @* begin
        if (!slow_sel) begin
            want_r = S_SLOW;
        end else if (pll_sel && free_run) begin
            want_r = S_PLL;
        end else if (pll_sel && lock_r && regulator_ready_flag_in) begin
            want_r = S_PLL;
        end else if (pll_sel && !pll_off && ref_lost) begin
            want_r = S_PLL;
        end else begin
            want_r = S_REF;
        end
    end

    // switcher: hold output low for a settle gap between sources
    wire cur_tick = (src_r == S_PLL) ? pll_clk_r :
        (src_r == S_SLOW) ? slow_clk_r :
        (src_r == S_REF) ? ref_tick : 1'b0;
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            src_r <= S_REF;
            settle_r <= 3'h0;
            sys_clk_out <= 1'b0;
        end else begin
            sys_clk_out <= cur_tick;
            if (src_r == S_QUIET) begin
                if (settle_r == 3'h0) begin
                    src_r <= want_r;
                end else begin
                    settle_r <= settle_r - 3'h1;
                end
            end else if (want_r != src_r && !cur_tick) begin
                // only leave a source between ticks, no runt pulse
                src_r <= S_QUIET;
                settle_r <= `SWITCH_SETTLE;
            end
        end
    end

    // flags and registers
    wire wr_cfr = wr_in && (addr_in == `CFR_ADDR);
    wire low_power_wait_mode = wfi_in && ccr_r[`CCR_LPW];
    always @* begin
        cfr_nxt = cfr_r;
        if (wr_cfr) begin
            cfr_nxt[`CFR_HALVE] = wdata_in[`CFR_HALVE];
            cfr_nxt[`CFR_SLOW] = wdata_in[`CFR_SLOW];
            cfr_nxt[`CFR_PLLSEL] = wdata_in[`CFR_PLLSEL];
            if (wdata_in[`CFR_STOP_I]) cfr_nxt[`CFR_STOP_I] = 1'b0;
            if (wdata_in[`CFR_SLOW_I]) cfr_nxt[`CFR_SLOW_I] = 1'b0;
            if (wdata_in[`CFR_LOCK_I]) cfr_nxt[`CFR_LOCK_I] = 1'b0;
        end
        if (low_power_wait_mode) begin
            cfr_nxt[`CFR_SLOW] = 1'b0;
        end
        cfr_nxt[`CFR_LOCK] = lock_r;
        // set beats clear in the same cycle
        if (cfr_nxt[`CFR_SLOW] != cfr_r[`CFR_SLOW]) begin
            cfr_nxt[`CFR_SLOW_I] = 1'b1;
        end
        if (lock_r != cfr_r[`CFR_LOCK]) begin
            cfr_nxt[`CFR_LOCK_I] = 1'b1;
        end
        if (stop_wake_in) begin
            cfr_nxt[`CFR_STOP_I] = 1'b1;
        end
    end

    always @(posedge core_clk_in) begin
        if (rst_in) begin
            cfr_r <= `CFR_RESET;
            ccr_r <= 16'h0000;
            plc_r <= `PLC_RESET;
            rtc_r <= {RTW{1'b0}};
            pcg_r <= {NPER{1'b0}};
            rdata_out <= 16'h0000;
        end else begin
            cfr_r <= cfr_nxt;
            if (wr_in) begin
                if (addr_in == `CCR_ADDR) begin
                    ccr_r <= wdata_in & 16'h0E81;
                end else if (addr_in == `PLC_ADDR) begin
                    plc_r <= wdata_in[7:0] & 8'hB7;
                end else if (addr_in == `RTC_ADDR) begin
                    rtc_r <= wdata_in[RTW-1:0];
                end else if (addr_in == `PCG_ADDR) begin
                    pcg_r <= wdata_in[NPER-1:0];
                end
            end
            rdata_out <= 16'h0000;
            if (rd_in) begin
                if (addr_in == `CCR_ADDR) begin
                    rdata_out <= ccr_r;
                end else if (addr_in == `VRC_ADDR) begin
                    rdata_out <= {13'h0, regulator_ready_flag_in, 2'h0};
                end else if (addr_in == `CFR_ADDR) begin
                    rdata_out <= cfr_r;
                end else if (addr_in == `PLC_ADDR) begin
                    rdata_out <= {8'h00, plc_r};
                end else if (addr_in == `RTC_ADDR) begin
                    rdata_out <= {{(16-RTW){1'b0}}, rtc_r};
                end else if (addr_in == `PCG_ADDR) begin
                    rdata_out <= {{(16-NPER){1'b0}}, pcg_r};
                end
            end
        end
    end

    assign irq_req_out[0] = cfr_r[`CFR_SLOW_I] & ccr_r[`CCR_EN_SLOW];
    assign irq_req_out[1] = cfr_r[`CFR_LOCK_I] & ccr_r[`CCR_EN_LOCK];
    assign irq_req_out[2] = cfr_r[`CFR_STOP_I] & ccr_r[`CCR_EN_STOP];

    genvar g;
    generate
        for (g = 0; g < NPER; g = g + 1) begin : gates
            clock_gate_reset u_gate (
                .core_clk_in(core_clk_in),
                .rst_in(rst_in),
                .gate_in(pcg_r[g]),
                .clk_en_out(periph_clk_en_out[g]),
                .periph_rst_out(periph_rst_out[g])
            );
        end
    endgenerate

    rt_prescaler #(.W(RTW)) u_rt (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .osc_tick_in(osc_tick_in),
        .div_in(rtc_r),
        .rt_tick_out(rt_tick_out)
    );
endmodule // clock_generation_unit

// ==== clkgen_checker_assertions.sv ====
// port checker for the clock generation unit
// assumes bind onto clock_generation_unit, one clock, sync reset
`timescale 1ns/1ps
module clkgen_checker #(
    parameter NPER = 8,
    parameter RTW = 10
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire [3:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire sys_clk_out,
    input wire [NPER-1:0] periph_clk_en_out,
    input wire [NPER-1:0] periph_rst_out,
    input wire rt_tick_out,
    input wire [2:0] irq_req_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    reset_state_a: assert property (
        $past(rst_in) |-> periph_clk_en_out == '0 && &periph_rst_out)
        else $error("gates not in reset state");
    gate_follow_a: assert property (
        wr_in && addr_in == 4'h5
        |-> ##2 periph_clk_en_out[0] == $past(wdata_in[0], 2))
        else $error("gate output does not follow gate bit");
    gated_reset_a: assert property (
        !periph_clk_en_out[0] |-> periph_rst_out[0])
        else $error("stopped peripheral out of reset");
    held_reset_a: assert property (
        $rose(periph_clk_en_out[0]) |-> periph_rst_out[0] [*8])
        else $error("peripheral reset released early");
    held_release_a: assert property (
        $rose(periph_clk_en_out[0]) |-> ##[8:12] !periph_rst_out[0])
        else $error("peripheral reset never released");
    irq_mask_a: assert property (
        wr_in && addr_in == 4'h0 && wdata_in[10:9] == 2'h0 && !wdata_in[7]
        |=> ##1 irq_req_out == 3'h0)
        else $error("masked request forwarded");
    sys_tick_a: assert property (
        sys_clk_out |=> !sys_clk_out)
        else $error("system tick wider than one cycle");
    rt_tick_a: assert property (
        rt_tick_out |=> !rt_tick_out)
        else $error("realtime tick faster than divide by two");
endmodule // clkgen_checker

bind clock_generation_unit clkgen_checker #(.NPER(NPER), .RTW(RTW)) u_chk (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .sys_clk_out(sys_clk_out),
    .periph_clk_en_out(periph_clk_en_out),
    .periph_rst_out(periph_rst_out), .rt_tick_out(rt_tick_out),
    .irq_req_out(irq_req_out)
);

// ==== clock_consumer_model.sv ====
// consumer side: cpu counting the clocks it receives, peripheral 0 the clocks it gets while held in reset
// assumes tick outputs are one-cycle enables on the core clock
`timescale 1ns/1ps
module clock_consumer_model (
    input wire core_clk_in,
    input wire sys_clk_in,
    input wire rt_tick_in,
    input wire periph_en_in,
    input wire periph_rst_in,
    output logic [15:0] sys_count_out = 16'h0000,
    output logic [15:0] rt_count_out = 16'h0000,
    output logic [15:0] hold_count_out = 16'h0000
);
    always @(posedge core_clk_in) begin
        if (sys_clk_in)
            sys_count_out <= sys_count_out + 16'h0001;
        if (rt_tick_in)
            rt_count_out <= rt_count_out + 16'h0001;
        // clocked but still held: peripheral is not usable yet
        if (periph_en_in && periph_rst_in)
            hold_count_out <= hold_count_out + 16'h0001;
    end
endmodule // clock_consumer_model

// ==== clock_generation_unit_tb.sv ====
// self-checking bench for the clock generation unit
// assumes the bound checker and the consumer model beside the dut
`timescale 1ns/1ps
module clock_generation_unit_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic root = 1'b0;
    logic root_on = 1'b1;
    logic rdy = 1'b0;
    logic wfi = 1'b0;
    logic wake = 1'b0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    wire [15:0] rdata;
    wire sys;
    wire rt;
    wire [7:0] en;
    wire [7:0] prst;
    wire [2:0] irq;
    wire [15:0] sysc;
    wire [15:0] rtc;
    wire [15:0] hold;
    int fail_count = 0;
    int n_checks = 0;

    always #5 clk = ~clk;
    // one root rising edge every two cycles; also the oscillator tick
    always @(posedge clk) root <= root_on ? ~root : 1'b0;

    clock_generation_unit #(.NPER(8), .RTW(10)) dut (
        .core_clk_in(clk), .rst_in(rst), .root_clock_in(root),
        .osc_tick_in(root), .regulator_ready_flag_in(rdy),
        .wfi_in(wfi), .stop_wake_in(wake), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
        .sys_clk_out(sys), .periph_clk_en_out(en),
        .periph_rst_out(prst), .rt_tick_out(rt), .irq_req_out(irq)
    );
    clock_consumer_model u_cons (
        .core_clk_in(clk), .sys_clk_in(sys), .rt_tick_in(rt),
        .periph_en_in(en[0]), .periph_rst_in(prst[0]),
        .sys_count_out(sysc), .rt_count_out(rtc), .hold_count_out(hold)
    );

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // window is a whole number of periods, so the count is exact
    task automatic rate(input bit use_rt, input int n, input logic [15:0] e);
        logic [15:0] c0;
        #1 c0 = use_rt ? rtc : sysc;
        repeat (n) @(posedge clk);
        #1 chk((use_rt ? rtc : sysc) - c0, e);
    endtask

    task automatic pulse(input bit use_wfi);
        @(posedge clk);
        if (use_wfi)
            wfi <= 1'b1;
        else
            wake <= 1'b1;
        @(posedge clk);
        wfi <= 1'b0;
        wake <= 1'b0;
    endtask

    task automatic t_reset;
        rd(4'h2, 16'h8008);
        rd(4'h3, 16'h0007);
        rd(4'h0, 16'h0000);
        rd(4'hF, 16'h0000);
        rate(1'b0, 400, 16'h0064);
        wr(4'h2, 16'h0008);
        idle(20);
        rate(1'b0, 400, 16'h00C8);
    endtask

    task automatic t_slow;
        wr(4'h0, 16'h0200);
        wr(4'h2, 16'h0000);
        idle(40);
        rate(1'b0, 640, 16'h0014);
        rd(4'h2, 16'h2000);
        chk({13'h0000, irq}, 16'h0001);
        wr(4'h2, 16'h0000);
        rd(4'h2, 16'h2000);
        wr(4'h2, 16'h2000);
        rd(4'h2, 16'h0000);
        chk({13'h0000, irq}, 16'h0000);
        wr(4'h0, 16'h0000);
        wr(4'h2, 16'h0008);
        idle(40);
        rd(4'h2, 16'h2008);
        chk({13'h0000, irq}, 16'h0000);
        wr(4'h2, 16'h2008);
    endtask

    task automatic t_pll;
        wr(4'h3, 16'h0010);
        idle(300);
        rd(4'h2, 16'h080A);
        wr(4'h2, 16'h0809);
        idle(20);
        // regulator not ready: pll stays off the system clock
        rate(1'b0, 400, 16'h00C8);
        @(posedge clk);
        rdy <= 1'b1;
        idle(20);
        // x12, divide by 1, reference every 2 cycles: 3 ticks per 16
        rate(1'b0, 640, 16'h0078);
        @(posedge clk);
        root_on <= 1'b0;
        idle(300);
        rate(1'b0, 640, 16'h0078);
        @(posedge clk);
        root_on <= 1'b1;
        idle(200);
        wr(4'h3, 16'h0000);
        idle(10);
        rd(4'h2, 16'h0809);
        rate(1'b0, 80, 16'h0028);
        @(posedge clk);
        rdy <= 1'b0;
        wr(4'h3, 16'h0007);
        wr(4'h2, 16'h0808);
        idle(10);
        rd(4'h2, 16'h0008);
        wr(4'h3, 16'h0087);
        wr(4'h2, 16'h0009);
        idle(20);
        // free run: x20 over 8, no lock and no regulator needed
        rate(1'b0, 640, 16'h0019);
        wr(4'h2, 16'h0008);
        idle(10);
        wr(4'h3, 16'h0007);
    endtask

    task automatic t_stop;
        wr(4'h0, 16'h0400);
        pulse(1'b0);
        idle(3);
        chk({13'h0000, irq}, 16'h0004);
        rd(4'h2, 16'h4008);
        wr(4'h0, 16'h0000);
        idle(1);
        chk({13'h0000, irq}, 16'h0000);
        wr(4'h0, 16'h0400);
        idle(1);
        chk({13'h0000, irq}, 16'h0004);
        wr(4'h2, 16'h4008);
        idle(2);
        chk({13'h0000, irq}, 16'h0000);
    endtask

    task automatic t_gate;
        logic [15:0] c0;
        c0 = hold;
        wr(4'h5, 16'h0001);
        idle(20);
        chk(hold - c0, 16'h0008);
        chk({14'h0000, en[0], prst[0]}, 16'h0002);
        wr(4'h5, 16'h0000);
        idle(3);
        chk({14'h0000, en[0], prst[0]}, 16'h0001);
    endtask

    task automatic t_rt;
        wr(4'h4, 16'h0001);
        idle(20);
        rate(1'b1, 320, 16'h0050);
        wr(4'h4, 16'h03FF);
        idle(20);
        rate(1'b1, 4096, 16'h0002);
    endtask

    task automatic t_wfi;
        pulse(1'b1);
        idle(10);
        rate(1'b0, 400, 16'h00C8);
        wr(4'h0, 16'h0001);
        pulse(1'b1);
        idle(40);
        rd(4'h2, 16'h2000);
        rate(1'b0, 640, 16'h0014);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_slow();
        t_pll();
        t_stop();
        t_gate();
        t_rt();
        t_wfi();
        stop_test();
    end

    // whole run is near 10500 cycles; a hang stops well past that
    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule // clock_generation_unit_tb
